// [shared/serial_port_pkg.sv]
package serial_port_pkg;

  localparam int ADDR_W = 12;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_POWER_CONTROL  = 12'h087;
  localparam logic [11:0] IDX_SERIAL_CONTROL = 12'h098;
  localparam logic [11:0] IDX_SERIAL_DATA    = 12'h099;
  localparam logic [11:0] IDX_BAUD_DIVISOR   = 12'h09a;
  localparam logic [11:0] ADDR_POWER_CONTROL  = IDX_POWER_CONTROL << 2;
  localparam logic [11:0] ADDR_SERIAL_CONTROL = IDX_SERIAL_CONTROL << 2;
  localparam logic [11:0] ADDR_SERIAL_DATA    = IDX_SERIAL_DATA << 2;
  localparam logic [11:0] ADDR_BAUD_DIVISOR   = IDX_BAUD_DIVISOR << 2;

  // Serial control field positions.
  localparam int BIT_MODE_LOW_OR_FE = 7;
  localparam int BIT_MODE_HIGH      = 6;
  localparam int BIT_MULTIPROC      = 5;
  localparam int BIT_RX_ENABLE      = 4;
  localparam int BIT_TX_NINTH       = 3;
  localparam int BIT_RX_NINTH       = 2;
  localparam int BIT_TX_DONE        = 1;
  localparam int BIT_RX_DONE        = 0;

  // Power control field positions.
  localparam int BIT_BAUD_DOUBLER = 7;
  localparam int BIT_FE_VIEW      = 6;

  localparam logic [7:0]  POWER_CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [15:0] BAUD_DIVISOR_RESET   = 16'h0005;

  // Fixed dividers of the core clock.
  localparam int M0_DIV_FAST = 4;
  localparam int M0_DIV_SLOW = 12;
  localparam int M2_DIV_FAST = 32;
  localparam int M2_DIV_SLOW = 64;
  localparam int OS_NORMAL   = 16;
  localparam int OS_DOUBLED  = 8;

  localparam logic [15:0] M0_HALF_FAST = 16'(M0_DIV_FAST / 2 - 1);
  localparam logic [15:0] M0_HALF_SLOW = 16'(M0_DIV_SLOW / 2 - 1);
  localparam logic [15:0] M2_TICK_LIM  = 16'(M2_DIV_SLOW / OS_NORMAL - 1);
  localparam logic [4:0]  OS_LAST_NORM = 5'(OS_NORMAL - 1);
  localparam logic [4:0]  OS_LAST_DBL  = 5'(OS_DOUBLED - 1);
  localparam logic [4:0]  OS_HALF_NORM = 5'(OS_NORMAL / 2 - 1);
  localparam logic [4:0]  OS_HALF_DBL  = 5'(OS_DOUBLED / 2 - 1);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_SYNC8        = 2'b00,
    MODE_ASYNC10      = 2'b01,
    MODE_ASYNC11_FIX  = 2'b10,
    MODE_ASYNC11_VAR  = 2'b11
  } serial_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_POWER, SEL_SERIAL, SEL_DATA, SEL_DIVISOR
  } reg_sel_t;

endpackage

// [shared/baud_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface baud_if;
  import serial_port_pkg::*;
  serial_mode_t mode;
  logic         doubler;
  logic [15:0]  divisor;
  logic         tick;
  modport gen  (input mode, input doubler, input divisor, output tick);
  modport core (output mode, output doubler, output divisor, input tick);
endinterface
`default_nettype wire

// [rtl/baud_tick_gen.sv]
`timescale 1ns/100ps
`default_nettype none
module baud_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  baud_if.gen      bus
);
  import serial_port_pkg::*;

  logic [15:0] cnt;
  logic [15:0] limit;

  // In mode 0 the tick marks half a shift-clock period, elsewhere one oversample.
  always_comb begin
    unique case (bus.mode)
      MODE_SYNC8:       limit = bus.doubler ? M0_HALF_FAST : M0_HALF_SLOW;
      MODE_ASYNC11_FIX: limit = M2_TICK_LIM;
      MODE_ASYNC10:     limit = bus.divisor;
      MODE_ASYNC11_VAR: limit = bus.divisor;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= 16'h0000;
      bus.tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt      <= 16'h0000;
      bus.tick <= 1'b1;
    end else begin
      cnt      <= cnt + 16'h0001;
      bus.tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/serial_port_control.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_port_control #(
  parameter logic [15:0] DIVISOR_RESET = serial_port_pkg::BAUD_DIVISOR_RESET
) (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic [serial_port_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                               awvalid,
  output var  logic                               awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output var  logic                               wready,
  output var  logic [1:0]                         bresp,
  output var  logic                               bvalid,
  input  wire logic                               bready,
  input  wire logic [serial_port_pkg::ADDR_W-1:0] araddr,
  input  wire logic                               arvalid,
  output var  logic                               arready,
  output var  logic [31:0]                        rdata,
  output var  logic [1:0]                         rresp,
  output var  logic                               rvalid,
  input  wire logic                               rready,
  output var  logic                               txd,
  input  wire logic                               rxd_in,
  output var  logic                               rxd_out,
  output var  logic                               rxd_oe
);
  import serial_port_pkg::*;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001, TX_ASYNC = 3'b010, TX_SYNC = 3'b100
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100, RX_SYNC = 4'b1000
  } rx_state_t;

  function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_POWER_CONTROL:  reg_sel = SEL_POWER;
      ADDR_SERIAL_CONTROL: reg_sel = SEL_SERIAL;
      ADDR_SERIAL_DATA:    reg_sel = SEL_DATA;
      ADDR_BAUD_DIVISOR:   reg_sel = SEL_DIVISOR;
      default:             reg_sel = SEL_NONE;
    endcase
  endfunction

  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_full;
  logic              w_full;
  logic              mode_low;
  logic              mode_select_high;
  logic              multiproc_check;
  logic              rx_enable;
  logic              tx_ninth_bit;
  logic              rx_ninth_bit;
  logic              tx_done_flag;
  logic              rx_done_flag;
  logic              frame_err;
  logic              baud_doubler;
  logic              frame_err_view_select;
  logic [5:0]        power_misc;
  logic [15:0]       divisor;
  logic [7:0]        rx_data;
  tx_state_t         tx_state;
  rx_state_t         rx_state;
  logic [10:0]       tx_frame;
  logic [3:0]        tx_bit;
  logic [4:0]        tx_os;
  logic              tx_phase;
  logic              ti_set;
  logic [9:0]        rx_shift;
  logic [3:0]        rx_bit;
  logic [4:0]        rx_os;
  logic              rx_phase;
  logic              rxd_prev;
  logic              ri_set;
  logic              fe_set;
  logic              next_txd;

  baud_if baud ();
  baud_tick_gen u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (baud)
  );

  serial_mode_t mode;
  assign mode = serial_mode_t'({mode_low, mode_select_high});
  assign baud.mode    = mode;
  assign baud.doubler = baud_doubler;
  assign baud.divisor = divisor;

  wire       tick    = baud.tick;
  wire [4:0] os_last = baud_doubler ? OS_LAST_DBL : OS_LAST_NORM;
  wire [4:0] os_half = baud_doubler ? OS_HALF_DBL : OS_HALF_NORM;
  wire [3:0] tx_last = (mode == MODE_ASYNC10) ? 4'h9 : 4'ha;
  wire [3:0] rx_last = (mode == MODE_ASYNC10) ? 4'h8 : 4'h9;

  wire      do_write  = aw_full && w_full && !bvalid;
  reg_sel_t wsel;
  assign wsel = reg_sel(awaddr_q);
  wire sc_write = do_write && (wsel == SEL_SERIAL) && wstrb_q[0];
  wire pc_write = do_write && (wsel == SEL_POWER) && wstrb_q[0];
  wire tx_start = do_write && (wsel == SEL_DATA) && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full  <= 1'b1;
        awaddr_q <= awaddr;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
      end
      if (do_write) begin
        bvalid  <= 1'b1;
        bresp   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        aw_full <= 1'b0;
        w_full  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      unique case (reg_sel(araddr))
        SEL_POWER:   rdata <= {24'h000000, baud_doubler, frame_err_view_select, power_misc};
        SEL_SERIAL:  rdata <= {24'h000000, frame_err_view_select ? frame_err : mode_low,
                               mode_select_high, multiproc_check, rx_enable, tx_ninth_bit,
                               rx_ninth_bit, tx_done_flag, rx_done_flag};
        SEL_DATA:    rdata <= {24'h000000, rx_data};
        SEL_DIVISOR: rdata <= {16'h0000, divisor};
        SEL_NONE: begin
          rdata <= 32'h00000000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {mode_low, mode_select_high, multiproc_check, rx_enable, tx_ninth_bit} <=
        SERIAL_CONTROL_RESET[7:3];
      {baud_doubler, frame_err_view_select, power_misc} <= POWER_CONTROL_RESET;
      divisor <= DIVISOR_RESET;
    end else begin
      if (sc_write) begin
        if (!frame_err_view_select) begin
          mode_low <= wdata_q[BIT_MODE_LOW_OR_FE];
        end
        mode_select_high <= wdata_q[BIT_MODE_HIGH];
        multiproc_check  <= wdata_q[BIT_MULTIPROC];
        rx_enable        <= wdata_q[BIT_RX_ENABLE];
        tx_ninth_bit     <= wdata_q[BIT_TX_NINTH];
      end
      if (pc_write) begin
        {baud_doubler, frame_err_view_select, power_misc} <= wdata_q[7:0];
      end
      if (do_write && (wsel == SEL_DIVISOR)) begin
        if (wstrb_q[0]) begin
          divisor[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          divisor[15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  // Hardware only ever sets the flags, and a set beats a same-cycle software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_flag <= SERIAL_CONTROL_RESET[BIT_TX_DONE];
      rx_done_flag <= SERIAL_CONTROL_RESET[BIT_RX_DONE];
      frame_err    <= 1'b0;
    end else begin
      if (ti_set) begin
        tx_done_flag <= 1'b1;
      end else if (sc_write) begin
        tx_done_flag <= wdata_q[BIT_TX_DONE];
      end
      if (ri_set) begin
        rx_done_flag <= 1'b1;
      end else if (sc_write) begin
        rx_done_flag <= wdata_q[BIT_RX_DONE];
      end
      if (fe_set) begin
        frame_err <= 1'b1;
      end else if (sc_write && frame_err_view_select) begin
        frame_err <= wdata_q[BIT_MODE_LOW_OR_FE];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_frame <= 11'h7ff;
      tx_bit   <= 4'h0;
      tx_os    <= 5'h00;
      tx_phase <= 1'b0;
      ti_set   <= 1'b0;
    end else begin
      ti_set <= 1'b0;
      unique case (tx_state)
        TX_IDLE: begin
          tx_bit   <= 4'h0;
          tx_os    <= 5'h00;
          tx_phase <= 1'b0;
          if (tx_start && mode == MODE_SYNC8 && rx_state != RX_SYNC) begin
            tx_frame <= {3'b111, wdata_q[7:0]};
            tx_state <= TX_SYNC;
          end else if (tx_start && mode != MODE_SYNC8) begin
            tx_frame <= {1'b1, (mode == MODE_ASYNC10) ? 1'b1 : tx_ninth_bit,
                         wdata_q[7:0], 1'b0};
            tx_state <= TX_ASYNC;
          end
        end
        TX_ASYNC: begin
          if (tick && tx_os == os_last) begin
            tx_os <= 5'h00;
            if (tx_bit == tx_last) begin
              tx_state <= TX_IDLE;
            end else begin
              tx_frame <= {1'b1, tx_frame[10:1]};
              tx_bit   <= tx_bit + 4'h1;
              ti_set   <= (tx_bit + 4'h1 == tx_last);
            end
          end else if (tick) begin
            tx_os <= tx_os + 5'h01;
          end
        end
        TX_SYNC: begin
          if (tick) begin
            tx_phase <= ~tx_phase;
            if (tx_phase && tx_bit == 4'h7) begin
              ti_set   <= 1'b1;
              tx_state <= TX_IDLE;
            end else if (tx_phase) begin
              tx_frame <= {1'b1, tx_frame[10:1]};
              tx_bit   <= tx_bit + 4'h1;
            end
          end
        end
      endcase
    end
  end

  wire rx_accept = !multiproc_check ||
                   ((mode == MODE_ASYNC10) ? rxd_in : rx_shift[9]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state     <= RX_IDLE;
      rx_shift     <= 10'h000;
      rx_bit       <= 4'h0;
      rx_os        <= 5'h00;
      rx_phase     <= 1'b0;
      rxd_prev     <= 1'b1;
      ri_set       <= 1'b0;
      fe_set       <= 1'b0;
      rx_data      <= 8'h00;
      rx_ninth_bit <= SERIAL_CONTROL_RESET[BIT_RX_NINTH];
    end else begin
      rxd_prev <= rxd_in;
      ri_set   <= 1'b0;
      fe_set   <= 1'b0;
      if (sc_write) begin
        rx_ninth_bit <= wdata_q[BIT_RX_NINTH];
      end
      unique case (rx_state)
        RX_IDLE: begin
          rx_os    <= 5'h00;
          rx_bit   <= 4'h0;
          rx_phase <= 1'b0;
          if (rx_enable && mode == MODE_SYNC8 && !rx_done_flag &&
              tx_state == TX_IDLE && !tx_start) begin
            rx_state <= RX_SYNC;
          end else if (rx_enable && mode != MODE_SYNC8 && rxd_prev && !rxd_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (!rx_enable) begin
            rx_state <= RX_IDLE;
          end else if (tick && rx_os == os_half) begin
            rx_os    <= 5'h00;
            rx_state <= rxd_in ? RX_IDLE : RX_BITS;
          end else if (tick) begin
            rx_os <= rx_os + 5'h01;
          end
        end
        RX_BITS: begin
          if (!rx_enable) begin
            rx_state <= RX_IDLE;
          end else if (tick && rx_os == os_last) begin
            rx_os    <= 5'h00;
            rx_shift <= {rxd_in, rx_shift[9:1]};
            rx_bit   <= rx_bit + 4'h1;
            if (rx_bit == rx_last) begin
              rx_state <= RX_IDLE;
              fe_set   <= !rxd_in;
              if (rx_accept) begin
                ri_set       <= 1'b1;
                rx_data      <= (mode == MODE_ASYNC10) ? rx_shift[9:2] : rx_shift[8:1];
                rx_ninth_bit <= (mode == MODE_ASYNC10) ? rxd_in : rx_shift[9];
              end
            end
          end else if (tick) begin
            rx_os <= rx_os + 5'h01;
          end
        end
        RX_SYNC: begin
          if (!rx_enable) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            rx_phase <= ~rx_phase;
            if (!rx_phase) begin
              rx_shift <= {rxd_in, rx_shift[9:1]};
            end else if (rx_bit == 4'h7) begin
              ri_set   <= 1'b1;
              rx_data  <= rx_shift[9:2];
              rx_state <= RX_IDLE;
            end else begin
              rx_bit <= rx_bit + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // In mode 0 the transmit line carries the shift clock and the receive line the data.
  always_comb begin
    if (tx_state == TX_SYNC) begin
      next_txd = tx_phase;
    end else if (rx_state == RX_SYNC) begin
      next_txd = rx_phase;
    end else if (tx_state == TX_ASYNC) begin
      next_txd = tx_frame[0];
    end else begin
      next_txd = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      txd     <= next_txd;
      rxd_out <= tx_frame[0];
      rxd_oe  <= (tx_state == TX_SYNC);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stop_starts;
    tx_state == TX_ASYNC && tick && tx_os == os_last && tx_bit + 4'h1 == tx_last;
  endsequence
  sequence s_rx_final;
    rx_state == RX_BITS && rx_enable && tick && rx_os == os_last && rx_bit == rx_last;
  endsequence

  a_ti_stop_start: assert property (s_stop_starts |-> ##2 tx_done_flag)
    else $error("transmit done not set at stop bit start");
  a_ti_held: assert property (tx_done_flag && !(sc_write && !wdata_q[BIT_TX_DONE])
                              |=> tx_done_flag)
    else $error("transmit done cleared without software");
  a_ri_held: assert property (rx_done_flag && !(sc_write && !wdata_q[BIT_RX_DONE])
                              |=> rx_done_flag)
    else $error("receive done cleared without software");
  a_fe_held: assert property (frame_err && !(sc_write && frame_err_view_select &&
                              !wdata_q[BIT_MODE_LOW_OR_FE]) |=> frame_err)
    else $error("frame error cleared without software");
  a_fe_bad_stop: assert property (s_rx_final and (!rxd_in) |-> ##2 frame_err)
    else $error("bad stop bit did not set frame error");
  a_mp_reject: assert property (s_rx_final and (multiproc_check && mode != MODE_ASYNC10 &&
                                !rx_shift[9]) |=> !ri_set)
    else $error("multiprocessor check did not reject frame");
  a_ninth_capture: assert property (s_rx_final and (mode != MODE_ASYNC10 && rx_accept)
                                    |-> ##2 rx_ninth_bit == $past(rx_shift[9], 2))
    else $error("ninth bit not captured");
  a_stop_capture: assert property (s_rx_final and (mode == MODE_ASYNC10 && !multiproc_check)
                                   |-> ##2 rx_ninth_bit == $past(rxd_in, 2))
    else $error("stop bit not captured in mode 1");
  a_rx_disabled: assert property (!rx_enable |=> !ri_set && !fe_set)
    else $error("receive flag raised while disabled");
  a_mode2_tick: assert property ((mode == MODE_ASYNC11_FIX && tick) ##1
                                 (mode == MODE_ASYNC11_FIX) [*3] |=>
                                 tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
    else $error("mode 2 oversample period wrong");
  a_mode0_tick: assert property ((mode == MODE_SYNC8 && baud_doubler && tick) ##1
                                 (mode == MODE_SYNC8 && baud_doubler) |=> tick && !$past(tick))
    else $error("mode 0 fast half period wrong");

endmodule
`default_nettype wire

// [verif/remote_serial.sv]
`timescale 1ns/100ps
`default_nettype none
module remote_serial (
  input  wire logic aclk,
  input  wire logic txd,
  output var  logic rxd_in
);
  // The line rests at mark level between frames.
  initial rxd_in = 1'h1;
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rxd_in <= f[i];
      repeat (bc) @(posedge aclk);
    end
    rxd_in <= 1'h1;
  endtask
  // Each bit is sampled in its middle, timed from the falling start edge.
  task automatic recv(input int n, input int bc, output logic [10:0] f);
    f = 11'h000;
    @(negedge txd);
    repeat (bc / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bc) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// [verif/serial_port_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_port_control_tb;
  import serial_port_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, txd, rxd_in, rxd_out, rxd_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          fails = 0;
  int          n_tests = 0;
  serial_port_control #(.DIVISOR_RESET(16'h0000)) DUT (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .txd, .rxd_in, .rxd_out, .rxd_oe);
  remote_serial peer (.aclk(aclk), .txd(txd), .rxd_in(rxd_in));
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'h0;
      if (wready && wvalid) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic t_regs;
    rdc(ADDR_POWER_CONTROL, 32'h0);
    rdc(ADDR_SERIAL_CONTROL, 32'h0);
    wr(ADDR_POWER_CONTROL, 32'h3f);
    chk(32'(r), 32'(RESP_OKAY));
    rdc(ADDR_POWER_CONTROL, 32'h3f);
    chk(32'(r), 32'(RESP_OKAY));
    wr(12'h000, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    rdc(12'h000, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask
  task automatic t_tx(input logic [7:0] pw, input logic [7:0] ct, input int n, input int bc,
                      input logic [10:0] exp);
    logic [10:0] f;
    wr(ADDR_POWER_CONTROL, 32'(pw));
    wr(ADDR_SERIAL_CONTROL, 32'(ct));
    fork
      peer.recv(n, bc, f);
      wr(ADDR_SERIAL_DATA, 32'(exp[8:1]));
    join
    chk(32'(f), 32'(exp));
    rdc(ADDR_SERIAL_CONTROL, 32'(ct | 8'h02));
  endtask
  task automatic t_m0(input logic [7:0] pw, input logic [31:0] per);
    logic [7:0] v;
    time        t0;
    wr(ADDR_POWER_CONTROL, 32'(pw));
    wr(ADDR_SERIAL_CONTROL, 32'h00);
    fork
      wr(ADDR_SERIAL_DATA, 32'h96);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd);
        v[i] = rxd_out;
        if (i == 0) t0 = $time;
        if (i == 0) chk(32'(rxd_oe), 32'h1);
        if (i == 1) chk(32'($time - t0), per);
      end
    join
    chk(32'(v), 32'h96);
    repeat (8) @(posedge aclk);
    chk(32'(rxd_oe), 32'h0);
    rdc(ADDR_SERIAL_CONTROL, 32'h02);
  endtask
  task automatic t_rx(input logic [7:0] ct, input logic [10:0] fr, input logic [7:0] ec,
                      input logic [7:0] ed);
    wr(ADDR_SERIAL_CONTROL, 32'(ct));
    peer.send(fr, 11, 8);
    repeat (8) @(posedge aclk);
    rdc(ADDR_SERIAL_CONTROL, 32'(ec));
    rdc(ADDR_SERIAL_DATA, 32'(ed));
  endtask
  task automatic t_fe;
    wr(ADDR_POWER_CONTROL, 32'hc0);
    wr(ADDR_SERIAL_CONTROL, 32'h50);
    peer.send(11'h278, 11, 8);
    rd(ADDR_SERIAL_CONTROL);
    chk(d & 32'h80, 32'h80);
    peer.send(11'h678, 11, 8);
    rd(ADDR_SERIAL_CONTROL);
    chk(d & 32'h80, 32'h80);
    wr(ADDR_SERIAL_CONTROL, 32'h50);
    rd(ADDR_SERIAL_CONTROL);
    chk(d & 32'h80, 32'h00);
    wr(ADDR_POWER_CONTROL, 32'h80);
    rd(ADDR_SERIAL_CONTROL);
    chk(d & 32'h80, 32'h80);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_tx(8'h00, 8'h50, 10, 16, 11'h34a);
    t_tx(8'h80, 8'h88, 11, 32, 11'h678);
    t_tx(8'h00, 8'h80, 11, 64, 11'h41e);
    t_m0(8'h00, 32'h78);
    t_m0(8'h80, 32'h28);
    t_rx(8'h50, 11'h702, 8'h55, 8'h81);
    t_rx(8'hd0, 11'h678, 8'hd5, 8'h3c);
    t_rx(8'hf0, 11'h422, 8'hf0, 8'h3c);
    t_rx(8'hf0, 11'h644, 8'hf5, 8'h22);
    t_rx(8'h70, 11'h102, 8'h70, 8'h22);
    t_rx(8'hc0, 11'h678, 8'hc0, 8'h22);
    t_fe;
    tally_and_finish;
  end
  // The whole sequence needs about 2300 cycles; this bound cuts a hang short.
  initial begin
    #500000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
